// ---- rtl/serial_in_latched_sink_driver.v ----
// serial-in, latched, gated open-collector sink driver
// assumes host pins are asynchronous and sampled by clk
`include "sink_driver_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_in_latched_sink_driver #(
  parameter CHAIN_LEN = `CHAIN_LEN,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire clk,
  input wire reset_n,
  input wire serial_clk,
  input wire serial_data,
  input wire latch_load,
  input wire output_gate,
  output wire serial_out,
  output wire [2*CHAIN_LEN-1:0] sink_on,
  output wire [2*CHAIN_LEN-1:0] sink_oe,
  output wire [2*CHAIN_LEN-1:0] latch_state
);
  localparam CH = 2 * CHAIN_LEN;

  ////////////////////////////////////////////////////////////////
  wire [3:0] pins_sync;
  bit_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({output_gate, latch_load, serial_data, serial_clk}),
    .sync_out(pins_sync)
  );
  wire sclk_s = pins_sync[0];
  wire sdata_s = pins_sync[1];
  wire load_s = pins_sync[2];
  wire gate_s = pins_sync[3];

  reg sclk_prev_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_prev_reg;

  ////////////////////////////////////////////////////////////////
  // captured data bits queue before entering the chain
  wire fifo_in_ready;
  wire fifo_out_data;
  wire fifo_out_valid;
  bit_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(sdata_s),
    .in_valid(sclk_rise),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1)
  );
  // chain always drains, so fifo never stalls; one entry per cycle
  wire shift_en = fifo_out_valid;

  ////////////////////////////////////////////////////////////////
  // chain 0 holds channels 0..15, chain 1 channels 16..31, cascaded
  reg [CH-1:0] chain_reg;
  reg [CH-1:0] latch_reg;
  reg serial_out_reg;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_reg <= {CH{1'b0}};
    end else if (shift_en) begin
      chain_reg <= {chain_reg[CH-2:0], fifo_out_data};
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_reg <= 1'b0;
    end else begin
      serial_out_reg <= chain_reg[CH-1];
    end
  end

  // load level is transparent: latches follow chain while high
  genvar i;
  generate
    for (i = 0; i < CH; i = i + 1) begin : g_ch
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          latch_reg[i] <= 1'b0;
        end else if (load_s) begin
          latch_reg[i] <= chain_reg[i];
        end
      end
      assign sink_on[i] = gate_s & latch_reg[i];
      assign sink_oe[i] = gate_s & latch_reg[i];
    end
  endgenerate

  assign serial_out = serial_out_reg;
  assign latch_state = latch_reg;
endmodule
`default_nettype wire

// ---- rtl/sink_driver_defines.vh ----
// constants for the serial-in latched sink driver
// assumes a 10 MHz system clock that samples every host pin
// Behaviour
// - rising serial clock captures serial data into first chain stage
// - each later rising edge moves every stage one step toward serial out
// - serial output presents the final chain stage for cascading
// - 32 output channels with own latches, fed from two 16-bit chains
// - latch load high copies each chain stage into its latch
// - latches follow chain while load high, hold while load low
// - output gate low switches every sink driver off
// - output gate never changes latch contents
// - output gate high drives each output from its own latch
`ifndef SINK_DRIVER_DEFINES_VH
`define SINK_DRIVER_DEFINES_VH
`define CHANNELS 32
`define CHAIN_LEN 16
`define CLK_PERIOD_NS 100
`define SHIFT_TO_LOAD_NS 100
`define SHIFT_TO_LOAD_CYC (((`SHIFT_TO_LOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : ((`SHIFT_TO_LOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define FIFO_DEPTH 8
`define LATCH_RESET 32'h00000000
`endif

// ---- rtl/bit_sync.v ----
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ---- rtl/bit_fifo.v ----
// synchronous fifo with valid/ready on both sides
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/host_model.sv ----
// host model: shifts words msb first at 800 ns per bit, then strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output var logic serial_clk = 1'b0,
  output var logic serial_data = 1'b0,
  output var logic latch_load = 1'b0
);
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk) {serial_clk, serial_data} <= {1'b0, w[i]};
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    // released data line shows the inverse of the last bit
    @(posedge clk) {serial_clk, serial_data} <= {1'b0, ~w[0]};
    repeat (6) @(posedge clk);
  endtask
  // level hold of the load pin, for the latch bypass case
  task automatic load_level(input logic v);
    @(posedge clk) latch_load <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic strobe();
    latch_load <= 1'b1;
    @(posedge clk) latch_load <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/drv_sva.sv ----
// pin checker, bound to the driver top
`timescale 1ns/1ps
`default_nettype none
module drv_sva #(parameter CHAIN_LEN = 16) (
  input wire logic clk, reset_n, serial_clk, latch_load, output_gate, serial_out,
  input wire logic [2*CHAIN_LEN-1:0] sink_on, sink_oe, latch_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  oe_eq_a: assert property (sink_oe == sink_on) else $error("oe");
  gate_off_a: assert property (!output_gate[*3] |-> !sink_on) else $error("off");
  gate_on_a: assert property (output_gate[*3] |-> sink_on == latch_state)
    else $error("on");
  lat_hold_a: assert property (!latch_load[*4] |=> $stable(latch_state))
    else $error("hold");
  shift_idle_a: assert property (!serial_clk[*7] |=> $stable(serial_out))
    else $error("idle");
  load_copy_a: assert property ($rose(latch_load) |-> ##[3:4]
    latch_state[2*CHAIN_LEN-1] == serial_out) else $error("copy");
  cover property ($rose(latch_load));
  cover property ($fell(output_gate));
  cover property ($rose(serial_clk));
endmodule
bind serial_in_latched_sink_driver drv_sva #(.CHAIN_LEN(CHAIN_LEN)) drv_sva_i (.clk(clk),
  .reset_n(reset_n), .serial_clk(serial_clk), .latch_load(latch_load),
  .output_gate(output_gate), .serial_out(serial_out), .sink_on(sink_on), .sink_oe(sink_oe),
  .latch_state(latch_state));
`default_nettype wire

// ---- testbench/tb_serial_in_latched_sink_driver.sv ----
// bench: host model loads words; bench drives reset and gate
`timescale 1ns/1ps
`default_nettype none
module tb_serial_in_latched_sink_driver;
  logic clk = 1'b0, reset_n = 1'b0, output_gate = 1'b0;
  wire serial_clk, serial_data, latch_load, serial_out;
  wire [31:0] sink_on, sink_oe, latch_state;
  int fail_count = 0, checks = 0;
  always #50 clk = ~clk;
  host_model host_model_i (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data),
    .latch_load(latch_load));
  serial_in_latched_sink_driver serial_in_latched_sink_driver_i (.clk(clk), .reset_n(reset_n),
    .serial_clk(serial_clk), .serial_data(serial_data), .latch_load(latch_load),
    .output_gate(output_gate), .serial_out(serial_out), .sink_on(sink_on), .sink_oe(sink_oe),
    .latch_state(latch_state));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic gate(input logic v);
    @(posedge clk) output_gate <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_load();
    gate(1'h1);
    host_model_i.send(32'hc35a0f81);
    host_model_i.strobe();
    cmp(latch_state, 32'hc35a0f81);
    cmp(sink_on, 32'hc35a0f81);
    cmp(sink_oe, 32'hc35a0f81);
  endtask
  task automatic t_hold();
    host_model_i.send(32'h3ca5f07e);
    cmp(serial_out, 32'h0);
    gate(1'h0);
    cmp(sink_on, 32'h0);
    cmp(sink_oe, 32'h0);
    cmp(latch_state, 32'hc35a0f81);
    gate(1'h1);
    host_model_i.strobe();
    cmp(sink_on, 32'h3ca5f07e);
  endtask
  task automatic t_bypass();
    gate(1'h0);
    host_model_i.load_level(1'b1);
    host_model_i.send(32'h0ff0a55a);
    cmp(sink_on, 32'h0);
    cmp(latch_state, 32'h0ff0a55a);
    gate(1'h1);
    cmp(sink_on, 32'h0ff0a55a);
    host_model_i.load_level(1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    t_load();
    t_hold();
    t_bypass();
    tally_and_finish();
  end
endmodule
`default_nettype wire
